/* File: verilog/dmsi_consts.svh */
// Constants for the DRAM mode-set and initialization block.
`ifndef DMSI_CONSTS_SVH
`define DMSI_CONSTS_SVH
`define DMSI_WORD_W 18
`define DMSI_RESET_WORD 18'h00000
`define DMSI_BIT_ODT 9
`define DMSI_BIT_IMP 8
`define DMSI_BIT_DLL 7
`define DMSI_BIT_IGN 6
`define DMSI_BIT_AMX 5
`define DMSI_BL_HI 4
`define DMSI_BL_LO 3
`define DMSI_CFG_HI 2
`define DMSI_CFG_LO 0
`define DMSI_DLL_LOCK_CYC 11'd1024
`define DMSI_REFRESH_NOPS 11'd1024
`define DMSI_BANKS 8
`endif

/* File: verilog/dmsi_pkg.sv */
// Types for the DRAM mode-set and initialization block.
package dmsi_pkg;
    typedef enum logic [4:0] {
        DMSI_CMD_NOP = 5'h01,
        DMSI_CMD_MODE_SET = 5'h02,
        DMSI_CMD_REFRESH = 5'h04,
        DMSI_CMD_READ = 5'h08,
        DMSI_CMD_WRITE = 5'h10
    } dmsi_cmd_t;
    typedef enum logic [3:0] {
        DMSI_ST_POWERUP = 4'h1,
        DMSI_ST_MODESET = 4'h2,
        DMSI_ST_INIT = 4'h4,
        DMSI_ST_READY = 4'h8
    } dmsi_state_t;
endpackage

/* File: verilog/dmsi_mode_if.sv */
// Carrier between the mode decoder and the top.
`timescale 1ns/1ps
interface dmsi_mode_if;
    logic [17:0] word;
    logic [3:0] rowCycle;
    logic [3:0] readLat;
    logic [3:0] writeLat;
    logic [3:0] burstLen;
    logic illegal;
    modport dec(input word, output rowCycle, readLat, writeLat, burstLen,
        illegal);
    modport top(output word, input rowCycle, readLat, writeLat, burstLen,
        illegal);
endinterface

/* File: verilog/dmsi_mode_decode.sv */
// Decoder from mode word to latency, cycle and burst figures.
`timescale 1ns/1ps
`include "dmsi_consts.svh"
module dmsi_mode_decode (
    dmsi_mode_if.dec m
);
    import dmsi_pkg::*;
    logic [2:0] cfg;
    logic [1:0] bl;
    logic mux;
    always_comb begin
        cfg = m.word[`DMSI_CFG_HI:`DMSI_CFG_LO];
        bl = m.word[`DMSI_BL_HI:`DMSI_BL_LO];
        mux = m.word[`DMSI_BIT_AMX];
        unique case (cfg)
            3'h2: m.rowCycle = 4'h6;
            3'h3: m.rowCycle = 4'h8;
            3'h4: m.rowCycle = 4'h3;
            3'h5: m.rowCycle = 4'h5;
            default: m.rowCycle = 4'h4;
        endcase
        m.readLat = m.rowCycle + {3'h0, mux};
        m.writeLat = m.readLat + 4'h1;
        unique case (bl)
            2'h0: m.burstLen = 4'h2;
            2'h1: m.burstLen = 4'h4;
            default: m.burstLen = 4'h8;
        endcase
        m.illegal = (bl == 2'h3) || (cfg[2:1] == 2'h3) ||
            ((bl == 2'h2) && (cfg == 3'h0 || cfg == 3'h1 || cfg == 3'h4));
    end
endmodule

/* File: verilog/dmsi_mode_set.sv */
// Mode word register and power-up sequencing of the DRAM.
`timescale 1ns/1ps
`include "dmsi_consts.svh"
module dmsi_mode_set (
    input wire logic mclk,
    input wire logic rst,
    input wire dmsi_pkg::dmsi_cmd_t cmdIn,
    input wire logic [2:0] bankIn,
    input wire logic [21:0] addrIn,
    output logic termEnable,
    output logic impedanceSourceSelect,
    output logic dllEnable,
    output logic addressMuxSelect,
    output logic [3:0] burstLength,
    output logic [3:0] rowCycleCycles,
    output logic [3:0] readLatencyCycles,
    output logic [3:0] writeLatencyCycles,
    output logic modeIllegal,
    output logic dllLocked,
    output logic initDone
);
    import dmsi_pkg::*;
    // ===========================================================
    // Input synchronisers
    // ===========================================================
    // Command pins are external, so they pass two stages first.
    dmsi_cmd_t cmdS1_q, cmdS2_q;
    logic [2:0] bankS1_q, bankS2_q;
    logic [21:0] addrS1_q, addrS2_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmdS1_q <= DMSI_CMD_NOP;
            cmdS2_q <= DMSI_CMD_NOP;
            bankS1_q <= 3'h0;
            bankS2_q <= 3'h0;
            addrS1_q <= 22'h000000;
            addrS2_q <= 22'h000000;
        end else begin
            cmdS1_q <= cmdIn;
            cmdS2_q <= cmdS1_q;
            bankS1_q <= bankIn;
            bankS2_q <= bankS1_q;
            addrS1_q <= addrIn;
            addrS2_q <= addrS1_q;
        end
    end
    // ===========================================================
    // Mode word and sequencing state
    // ===========================================================
    logic [17:0] word_q, word_d;
    dmsi_state_t state_q, state_d;
    logic [1:0] msCount_q, msCount_d;
    logic [10:0] nopCount_q, nopCount_d;
    logic [`DMSI_BANKS-1:0] refreshed_q, refreshed_d;
    logic [10:0] dllCount_q, dllCount_d;
    logic dllLocked_q, dllLocked_d;
    logic initDone_q, initDone_d;
    logic isMs;
    always_comb begin
        isMs = (cmdS2_q == DMSI_CMD_MODE_SET);
        word_d = word_q;
        state_d = state_q;
        msCount_d = msCount_q;
        nopCount_d = nopCount_q;
        refreshed_d = refreshed_q;
        dllCount_d = dllCount_q;
        dllLocked_d = dllLocked_q;
        initDone_d = initDone_q;
        if (isMs) begin
            word_d = addrS2_q[`DMSI_WORD_W-1:0];
            word_d[`DMSI_BIT_IGN] = 1'b0;
            word_d[`DMSI_BIT_AMX] = word_q[`DMSI_BIT_AMX] |
                addrS2_q[`DMSI_BIT_AMX];
        end
        if (isMs && !addrS2_q[`DMSI_BIT_DLL]) begin
            dllCount_d = 11'h000;
            dllLocked_d = 1'b0;
        end else if (word_q[`DMSI_BIT_DLL] && !dllLocked_q) begin
            dllCount_d = dllCount_q + 11'h001;
            dllLocked_d = (dllCount_d == `DMSI_DLL_LOCK_CYC);
        end
        unique case (state_q)
            DMSI_ST_POWERUP: begin
                if (isMs) begin
                    msCount_d = 2'h1;
                    state_d = DMSI_ST_MODESET;
                end
            end
            DMSI_ST_MODESET: begin
                if (isMs) begin
                    if (msCount_q != 2'h3) begin
                        msCount_d = msCount_q + 2'h1;
                    end
                end else if (msCount_q == 2'h3) begin
                    state_d = DMSI_ST_INIT;
                end else begin
                    msCount_d = 2'h0;
                    state_d = DMSI_ST_POWERUP;
                end
            end
            DMSI_ST_INIT: begin
                if (cmdS2_q == DMSI_CMD_REFRESH) begin
                    refreshed_d[bankS2_q] = 1'b1;
                end
                if (cmdS2_q == DMSI_CMD_NOP &&
                    nopCount_q != `DMSI_REFRESH_NOPS) begin
                    nopCount_d = nopCount_q + 11'h001;
                end
                if (&refreshed_q && nopCount_q == `DMSI_REFRESH_NOPS) begin
                    state_d = DMSI_ST_READY;
                    initDone_d = 1'b1;
                end
            end
            DMSI_ST_READY: begin
                initDone_d = 1'b1;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            word_q <= `DMSI_RESET_WORD;
            state_q <= DMSI_ST_POWERUP;
            msCount_q <= 2'h0;
            nopCount_q <= 11'h000;
            refreshed_q <= '0;
            dllCount_q <= 11'h000;
            dllLocked_q <= 1'b0;
            initDone_q <= 1'b0;
        end else begin
            word_q <= word_d;
            state_q <= state_d;
            msCount_q <= msCount_d;
            nopCount_q <= nopCount_d;
            refreshed_q <= refreshed_d;
            dllCount_q <= dllCount_d;
            dllLocked_q <= dllLocked_d;
            initDone_q <= initDone_d;
        end
    end
    // ===========================================================
    // Decoded figures, registered for clean outputs
    // ===========================================================
    dmsi_mode_if mi();
    assign mi.word = word_q;
    dmsi_mode_decode u_dec (
        .m(mi)
    );
    always_ff @(posedge mclk) begin
        if (rst) begin
            termEnable <= 1'b0;
            impedanceSourceSelect <= 1'b0;
            dllEnable <= 1'b0;
            addressMuxSelect <= 1'b0;
            burstLength <= 4'h2;
            rowCycleCycles <= 4'h4;
            readLatencyCycles <= 4'h4;
            writeLatencyCycles <= 4'h5;
            modeIllegal <= 1'b0;
            dllLocked <= 1'b0;
            initDone <= 1'b0;
        end else begin
            termEnable <= word_q[`DMSI_BIT_ODT];
            impedanceSourceSelect <= word_q[`DMSI_BIT_IMP];
            dllEnable <= word_q[`DMSI_BIT_DLL];
            addressMuxSelect <= word_q[`DMSI_BIT_AMX];
            burstLength <= mi.burstLen;
            rowCycleCycles <= mi.rowCycle;
            readLatencyCycles <= mi.readLat;
            writeLatencyCycles <= mi.writeLat;
            modeIllegal <= mi.illegal;
            dllLocked <= dllLocked_q;
            initDone <= initDone_q;
        end
    end
endmodule

/* File: test/dmsi_assertions.sv */
// Checker of the mode-set block outputs against the mode word.
`timescale 1ns/1ps
module dmsi_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire dmsi_pkg::dmsi_cmd_t cmdIn,
    input wire logic [21:0] addrIn,
    input wire logic termEnable,
    input wire logic impedanceSourceSelect,
    input wire logic dllEnable,
    input wire logic addressMuxSelect,
    input wire logic [3:0] burstLength,
    input wire logic [3:0] rowCycleCycles,
    input wire logic [3:0] readLatencyCycles,
    input wire logic [3:0] writeLatencyCycles,
    input wire logic modeIllegal,
    input wire logic dllLocked
);
    import dmsi_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic ms = (cmdIn == DMSI_CMD_MODE_SET);
    a_word_cap: assert property (ms |-> ##4
        {termEnable, impedanceSourceSelect, dllEnable} ==
        $past(addrIn[9:7], 4)) else $error("feature bits not captured");
    a_mux_set: assert property (ms && addrIn[5] |->
        ##4 addressMuxSelect) else $error("multiplexed mode not entered");
    a_mux_keep: assert property (!$past(rst) |->
        !$fell(addressMuxSelect)) else $error("multiplexed mode left");
    a_lat_pair: assert property (writeLatencyCycles ==
        readLatencyCycles + 4'h1) else $error("write latency not read+1");
    a_burst_four: assert property (ms && addrIn[4:3] == 2'b01 &&
        addrIn[2:1] != 2'b11 |-> ##4 burstLength == 4'h4)
        else $error("burst length 4 not decoded");
    a_bl_reserved: assert property (ms && addrIn[4:3] == 2'b11
        |-> ##4 modeIllegal) else $error("reserved burst not flagged");
    a_cfg_three: assert property (ms && addrIn[4:0] == 5'h04
        |-> ##4 rowCycleCycles == 4'h3) else $error("row cycle not 3");
    a_rl_mux: assert property (ms && addrIn[5] &&
        addrIn[4:0] == 5'h02 |-> ##4 readLatencyCycles == 4'h7)
        else $error("multiplexed read latency wrong");
    a_dll_wait: assert property ($rose(dllEnable) |->
        !dllLocked [*8]) else $error("lock came too early");
endmodule
bind dmsi_mode_set dmsi_assertions chk (.mclk, .rst, .cmdIn, .addrIn,
    .termEnable, .impedanceSourceSelect, .dllEnable, .addressMuxSelect,
    .burstLength, .rowCycleCycles, .readLatencyCycles,
    .writeLatencyCycles, .modeIllegal, .dllLocked);

/* File: test/dmsi_ctrl_model.sv */
// Behavioural memory controller that issues commands to the block.
`timescale 1ns/1ps
module dmsi_ctrl_model #(parameter int RECOVERY = 6) (
    input wire logic mclk,
    output dmsi_pkg::dmsi_cmd_t cmd,
    output logic [2:0] bank,
    output logic [21:0] addr
);
    import dmsi_pkg::*;
    initial begin
        cmd = DMSI_CMD_NOP;
        bank = 3'h0;
        addr = 22'h000000;
    end
    // Address toggles on NOPs so only a mode-set may be captured.
    task automatic nops(input int n);
        repeat (n) begin
            @(posedge mclk);
            cmd <= DMSI_CMD_NOP;
            addr <= ~addr;
        end
    endtask
    // recovery spans more than the four cycles a mode word takes to reach the outputs, no bursts issued.
    task automatic modeSet(input logic [21:0] w);
        @(posedge mclk);
        cmd <= DMSI_CMD_MODE_SET;
        addr <= w;
        nops(RECOVERY);
    endtask
    task automatic powerUp(input logic [21:0] w);
        repeat (2) begin
            @(posedge mclk);
            cmd <= DMSI_CMD_MODE_SET;
            addr <= 22'h000000;
        end
        modeSet(w);
    endtask
    task automatic refreshAll();
        for (int b = 0; b < 8; b++) begin
            @(posedge mclk);
            cmd <= DMSI_CMD_REFRESH;
            bank <= 3'(b);
        end
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the mode-set and initialization block.
`timescale 1ns/1ps
module testbench;
    import dmsi_pkg::*;
    typedef struct packed {
        logic [21:0] a;
        logic [20:0] e;
    } dmsi_row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    dmsi_cmd_t cmd;
    logic [2:0] bank;
    logic [21:0] addr;
    logic [3:0] bl, rc, rl, wl;
    logic ill, term, imp, dll, amx, locked, done;
    int errors = 0;
    int n_compared = 0;
    wire logic [20:0] obs = {bl, rc, rl, wl, ill, term, imp, dll, amx};
    dmsi_row_t rows [10] = '{
        '{22'h000000, {16'h2445, 5'h00}}, '{22'h00000a, {16'h4667, 5'h00}},
        '{22'h000013, {16'h8889, 5'h00}}, '{22'h000384, {16'h2334, 5'h0e}},
        '{22'h000005, {16'h2556, 5'h00}}, '{22'h200041, {16'h2445, 5'h00}},
        '{22'h000010, {16'h8445, 5'h10}}, '{22'h000006, {16'h2445, 5'h10}},
        '{22'h000018, {16'h8445, 5'h10}}, '{22'h000014, {16'h8334, 5'h10}}};
    // one clean clock, so no spurious command is decoded.
    always #12.5 mclk = ~mclk;
    dmsi_mode_set dut (.mclk, .rst, .cmdIn(cmd), .bankIn(bank),
        .addrIn(addr), .termEnable(term), .impedanceSourceSelect(imp),
        .dllEnable(dll), .addressMuxSelect(amx), .burstLength(bl),
        .rowCycleCycles(rc), .readLatencyCycles(rl),
        .writeLatencyCycles(wl), .modeIllegal(ill), .dllLocked(locked),
        .initDone(done));
    dmsi_ctrl_model ctl (.mclk, .cmd, .bank, .addr);
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        ctl.powerUp(22'h000000);
        ctl.refreshAll();
        ctl.nops(1000);
        @(negedge mclk);
        chk(21'(done), 21'h0);
        ctl.nops(40);
        @(negedge mclk);
        chk(21'(done), 21'h1);
        foreach (rows[i]) begin
            ctl.modeSet(rows[i].a);
            @(negedge mclk);
            chk(obs, rows[i].e);
        end
        // the recovery of modeSet passes before the next mode-set.
        ctl.modeSet(22'h000022);
        @(negedge mclk);
        chk(obs, {16'h2678, 5'h01});
        // Clearing bit five on purpose: the mode must not fall back.
        ctl.modeSet(22'h000000);
        @(negedge mclk);
        chk(obs, {16'h2456, 5'h01});
        ctl.modeSet(22'h0000a0);
        ctl.nops(1000);
        @(negedge mclk);
        chk(21'(locked), 21'h0);
        ctl.nops(40);
        @(negedge mclk);
        chk(21'(locked), 21'h1);
        // DLL put through reset before any later re-enable.
        ctl.modeSet(22'h000020);
        @(negedge mclk);
        chk(21'(locked), 21'h0);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk(obs, {16'h2445, 5'h00});
        chk(21'({locked, done}), 21'h0);
        close_out();
    end
    initial begin
        #125000;
        errors++;
        close_out();
    end
endmodule
